// ---- design/apt_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants for the power management timer block.
// ----------------------------------------------------------------------------
package apt_pkg;

  // --------------------------------------------------------------------------
  // Widths.
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 4;   // Byte offset inside the power management block.
  localparam int DATA_W = 8;   // Every register is one byte wide.
  localparam int COUNT_W = 24; // Width of the running count.
  localparam int CARRY_BIT = 23; // Top bit of the count, watched for carries.
  localparam int IDLE_W = 8;   // Width of the stopped-clock watch counter.

  // --------------------------------------------------------------------------
  // Register offsets relative to the block base in system I/O space.
  // --------------------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL_TWO = 4'h5;
  localparam logic [3:0] OFF_CONTROL_THREE = 4'h6;
  localparam logic [3:0] OFF_CONTROL_FOUR = 4'h7;
  localparam logic [3:0] OFF_TIMER_BYTE_LOW = 4'h8;
  localparam logic [3:0] OFF_TIMER_BYTE_MID = 4'h9;

  // --------------------------------------------------------------------------
  // Reset and read-back values.
  // --------------------------------------------------------------------------
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] COUNT_STEP = 24'h000001;
  localparam logic [7:0] IDLE_STEP = 8'h01;

  // --------------------------------------------------------------------------
  // Timing.
  // --------------------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 50;       // System clock rate in MHz.
  localparam int TICK_HZ = 3579545;      // Nominal rate of the timer input clock.
  localparam int PIN_STOP_NS = 1000;     // Input clock idle longer than this counts as stopped.
  localparam int PIN_STOP_CYCLES = (PIN_STOP_NS * CLK_SYS_MHZ) / 1000; // Rounded down.

endpackage : apt_pkg

// ---- design/apt_pm_timer.sv ----
`timescale 1ns/100ps

module apt_pm_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [3:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic inputClockPin,
  input wire logic systemWorking,
  input wire logic masterReset,
  input wire logic timerCarryClear,
  input wire logic timerCarryIrqEnable,
  input wire logic sciSelect,
  input wire logic smiEnable,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  output logic [23:0] pmTimerCount,
  output logic timerCarryFlag,
  output logic timerClockRunning,
  output logic sciOut,
  output logic smiOut
);

  // --------------------------------------------------------------------------
  // Address decode helpers.
  // --------------------------------------------------------------------------

  // The reserved test is needed by the read path and by the checks below.
  function automatic logic isReservedOffset(input logic [3:0] addr);
    isReservedOffset = (addr == apt_pkg::OFF_CONTROL_TWO) ||
                       (addr == apt_pkg::OFF_CONTROL_THREE) ||
                       (addr == apt_pkg::OFF_CONTROL_FOUR);
  endfunction : isReservedOffset

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic pinPrev_reg;
  logic flag_reg;
  logic flag_next;
  logic [7:0] idle_reg;
  logic [7:0] idle_next;
  logic running_reg;
  logic running_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdValid_reg;
  logic sci_reg;
  logic sci_next;
  logic smi_reg;
  logic smi_next;

  // --------------------------------------------------------------------------
  // Counting.
  // --------------------------------------------------------------------------

  // The input clock pin is synchronous to clk_sys, so a rising edge is found
  // by comparing with last cycle's sample. A stopped pin gives no edges and
  // the count simply holds, which is also how it resumes after a restart.
  wire logic pinRise = inputClockPin & ~pinPrev_reg;
  wire logic countAdvance = pinRise & systemWorking;
  wire logic [23:0] countInc = count_reg + apt_pkg::COUNT_STEP;

  // Master reset clears the count; otherwise it steps or holds. Bus writes
  // have no path into the count at all.
  assign count_next = masterReset ? apt_pkg::COUNT_RESET :
                      countAdvance ? countInc : count_reg;

  // A carry is any change of the top bit caused by counting. Clearing by
  // master reset is not treated as a carry so software sees no false event.
  wire logic carryEvent = countAdvance & ~masterReset &
                          (countInc[apt_pkg::CARRY_BIT] ^ count_reg[apt_pkg::CARRY_BIT]);

  // The flag is sticky; a carry in the same cycle as a clear wins.
  assign flag_next = carryEvent | (flag_reg & ~timerCarryClear);

  // --------------------------------------------------------------------------
  // Input clock watch.
  // --------------------------------------------------------------------------

  // Counts system cycles since the last pin edge and saturates, so software
  // can tell a held count from a slow one.
  wire logic idleFull = (idle_reg >= 8'(apt_pkg::PIN_STOP_CYCLES));
  assign idle_next = pinRise ? 8'h00 : (idleFull ? idle_reg : idle_reg + apt_pkg::IDLE_STEP);
  assign running_next = ~idleFull | pinRise;

  // --------------------------------------------------------------------------
  // Event routing.
  // --------------------------------------------------------------------------

  // The enabled carry flag is the power management event; it leaves as SCI
  // when SCI select is set and as SMI otherwise, if the SMI path is enabled.
  wire logic pmEvent = flag_reg & timerCarryIrqEnable;
  assign sci_next = pmEvent & sciSelect;
  assign smi_next = pmEvent & ~sciSelect & smiEnable;

  // --------------------------------------------------------------------------
  // Read path.
  // --------------------------------------------------------------------------

  // Reads only sample the count; they never feed back into it.
  wire logic selLow = (ioAddr == apt_pkg::OFF_TIMER_BYTE_LOW);
  wire logic selMid = (ioAddr == apt_pkg::OFF_TIMER_BYTE_MID);
  wire logic selReserved = isReservedOffset(ioAddr);
  assign rdData_next = selLow ? count_reg[7:0] :
                       selMid ? count_reg[15:8] :
                       selReserved ? apt_pkg::RESERVED_VALUE :
                       apt_pkg::UNMAPPED_VALUE;

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------

  // Counter and edge sample; reset acts even with the clock enable low.
  // The pin is sampled during reset, so a pin held high through reset is not taken as a rise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_reg <= apt_pkg::COUNT_RESET;
      pinPrev_reg <= inputClockPin;
    end else if (clkEnable) begin
      count_reg <= count_next;
      pinPrev_reg <= inputClockPin;
    end
  end

  // Carry flag and clock watch.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_reg <= 1'b0;
      idle_reg <= 8'(apt_pkg::PIN_STOP_CYCLES); // Reads as stopped until a first edge is seen.
      running_reg <= 1'b0;
    end else if (clkEnable) begin
      flag_reg <= flag_next;
      idle_reg <= idle_next;
      running_reg <= running_next;
    end
  end

  // Read answer, one cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
    end else if (clkEnable) begin
      rdData_reg <= ioRead ? rdData_next : rdData_reg;
      rdValid_reg <= ioRead;
    end
  end

  // Interrupt outputs, registered so they come straight from flip-flops.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sci_reg <= 1'b0;
      smi_reg <= 1'b0;
    end else if (clkEnable) begin
      sci_reg <= sci_next;
      smi_reg <= smi_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign ioRdData = rdData_reg;
  assign ioRdValid = rdValid_reg;
  assign pmTimerCount = count_reg;
  assign timerCarryFlag = flag_reg;
  assign timerClockRunning = running_reg;
  assign sciOut = sci_reg;
  assign smiOut = smi_reg;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------

  // A read request that is actually taken this cycle.
  sequence s_read_taken(logic [3:0] off);
    clkEnable && !reset && ioRead && (ioAddr == off);
  endsequence

  // A cycle in which the counter must not move.
  sequence s_count_quiet;
    clkEnable && !reset && !masterReset && !countAdvance;
  endsequence

  // A counting step that really happens.
  sequence s_count_step;
    clkEnable && !reset && !masterReset && pinRise && systemWorking;
  endsequence

  a_reserved_read_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && ioRead && isReservedOffset(ioAddr)) |=> (ioRdValid && ioRdData == 8'h00))
    else $error("Reserved control register read did not return zero.");

  a_low_byte_read: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_read_taken(apt_pkg::OFF_TIMER_BYTE_LOW) |=> (ioRdValid && ioRdData == $past(count_reg[7:0])))
    else $error("Low timer byte read does not match the count.");

  a_mid_byte_read: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_read_taken(apt_pkg::OFF_TIMER_BYTE_MID) |=> (ioRdValid && ioRdData == $past(count_reg[15:8])))
    else $error("Middle timer byte read does not match the count.");

  a_count_step_one: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_count_step |=> (count_reg == $past(count_reg) + 24'h000001))
    else $error("Counter did not step by one on an input clock edge.");

  a_count_holds: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_count_quiet |=> (count_reg == $past(count_reg)))
    else $error("Counter moved without an input clock edge in working state.");

  a_master_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && masterReset) |=> (count_reg == 24'h000000))
    else $error("Master reset did not clear the counter.");

  a_carry_sets_flag: assert property (
    @(posedge clk_sys) disable iff (reset)
    (s_count_step ##0 (count_next[23] != count_reg[23])) |=> timerCarryFlag)
    else $error("A change of count bit 23 did not set the carry flag.");

  a_sci_route: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && flag_reg && timerCarryIrqEnable && sciSelect) |=> (sciOut && !smiOut))
    else $error("Enabled carry flag with SCI select did not raise SCI.");

  a_smi_route: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && flag_reg && timerCarryIrqEnable && !sciSelect && smiEnable) |=> (smiOut && !sciOut))
    else $error("Enabled carry flag without SCI select did not raise SMI.");

  a_no_event_masked: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && !timerCarryIrqEnable) |=> (!sciOut && !smiOut))
    else $error("Interrupt raised while the carry interrupt enable was clear.");

  a_sci_needs_select: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && !sciSelect) |=> !sciOut)
    else $error("SCI raised while SCI select was clear.");

  // The flag holds until a clear, and a clear without a carry empties it.
  a_flag_sticky: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && flag_reg && !timerCarryClear) |=> timerCarryFlag)
    else $error("Carry flag dropped without a clear.");

  a_flag_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && timerCarryClear && !carryEvent) |=> !timerCarryFlag)
    else $error("Carry flag survived a clear with no carry.");

  // Master reset and idle cycles must never invent a carry.
  a_no_false_carry: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && !flag_reg && (masterReset || !countAdvance)) |=> !timerCarryFlag)
    else $error("Carry flag set without a counting step.");

  // Bus traffic of either kind leaves a quiet count where it was.
  a_write_ignored: assert property (
    @(posedge clk_sys) disable iff (reset)
    (s_count_quiet ##0 ioWrite) |=> $stable(count_reg))
    else $error("A bus write changed the count.");

  a_read_no_disturb: assert property (
    @(posedge clk_sys) disable iff (reset)
    (s_count_quiet ##0 ioRead) |=> $stable(count_reg))
    else $error("A bus read changed the count.");

  a_read_pulse_only: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && !ioRead) |=> !ioRdValid)
    else $error("Read valid raised without a read.");

  // Clock watch: an edge marks the pin running, a long silence marks it stopped.
  a_watch_on_edge: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && pinRise) |=> timerClockRunning)
    else $error("Clock watch missed an input clock edge.");

  a_watch_stopped: assert property (
    @(posedge clk_sys) disable iff (reset)
    (clkEnable && idleFull && !pinRise) |=> !timerClockRunning)
    else $error("Clock watch reports running after a long silence.");

  // A low clock enable freezes the count, the flag and the read answer.
  a_freeze_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    !clkEnable |=> ($stable(count_reg) && $stable(flag_reg) && $stable(ioRdValid)))
    else $error("State changed while the clock enable was low.");

endmodule : apt_pm_timer

// ---- verification/apt_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Host software model: random byte accesses in system I/O space.
// ----------------------------------------------------------------------------
module apt_host_model (
  input wire logic clk_sys,
  input wire logic hostOn,
  output logic [3:0] ioAddr,
  output logic ioRead,
  output logic ioWrite
);
  // Offsets span unmapped ones too, and writes hit the count to show they are dropped.
  initial begin
    ioAddr = 4'h0;
    ioRead = 1'b0;
    ioWrite = 1'b0;
    forever begin
      @(posedge clk_sys);
      #1;
      ioRead = hostOn & 1'($urandom_range(0, 1));
      ioWrite = hostOn & 1'($urandom_range(0, 1));
      ioAddr = 4'($urandom_range(0, 15));
    end
  end
endmodule : apt_host_model

// ---- verification/acpi_pm_timer_tb.sv ----
`timescale 1ns/100ps
module acpi_pm_timer_tb;
  logic clk_sys, reset, clkEnable, inputClockPin, systemWorking, masterReset, hostOn;
  logic timerCarryClear, timerCarryIrqEnable, sciSelect, smiEnable, ioRead, ioWrite;
  logic [3:0] ioAddr;
  logic [7:0] ioRdData, expData;
  logic [23:0] pmTimerCount;
  logic ioRdValid, timerCarryFlag, timerClockRunning, sciOut, smiOut;
  int fail_count = 0;
  int total_checks = 0;
  int expCount, held, sinceRise;
  bit prevPin, expValid, lastCe, expRun;

  apt_pm_timer dut_u (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable), .ioAddr(ioAddr),
    .ioRead(ioRead), .ioWrite(ioWrite), .inputClockPin(inputClockPin), .systemWorking(systemWorking),
    .masterReset(masterReset), .timerCarryClear(timerCarryClear), .timerCarryIrqEnable(timerCarryIrqEnable),
    .sciSelect(sciSelect), .smiEnable(smiEnable), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .pmTimerCount(pmTimerCount), .timerCarryFlag(timerCarryFlag), .timerClockRunning(timerClockRunning),
    .sciOut(sciOut), .smiOut(smiOut));
  apt_host_model host_u (.clk_sys(clk_sys), .hostOn(hostOn), .ioAddr(ioAddr), .ioRead(ioRead),
    .ioWrite(ioWrite));

  // ----------------------------------------------------------------------------
  // Reference model, updated from the inputs sampled at each edge.
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    lastCe = clkEnable;
    if (reset) begin
      expCount = 0;
      prevPin = inputClockPin;
      expValid = 1'b0;
      sinceRise = apt_pkg::PIN_STOP_CYCLES + 1;
      expRun = 1'b0;
    end else if (clkEnable) begin
      expValid = ioRead;
      if (ioRead) begin
        expData = (ioAddr == 4'h8) ? expCount[7:0] : (ioAddr == 4'h9) ? expCount[15:8] : 8'h00;
      end
      if (masterReset) expCount = 0;
      else if (inputClockPin && !prevPin && systemWorking) expCount = (expCount + 1) % (1 << 24);
      // The pin counts as running for a fixed span of enabled cycles after each rise.
      if (inputClockPin && !prevPin) sinceRise = 0;
      else if (sinceRise <= apt_pkg::PIN_STOP_CYCLES) sinceRise++;
      expRun = (sinceRise <= apt_pkg::PIN_STOP_CYCLES);
      prevPin = inputClockPin;
    end
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // Every result is compared once the edge has settled; a valid pulse frozen by a low
  // enable is left alone, since a frozen cycle is not a read answer.
  always @(posedge clk_sys) begin
    #2;
    if (!reset) begin
      check(pmTimerCount === 24'(expCount), "count differs");
      // A 24-bit wrap needs millions of steps, so bit 23 never toggles here.
      check(timerCarryFlag === 1'b0, "carry flag set");
      check(sciOut === 1'b0 && smiOut === 1'b0, "event without flag");
      if (lastCe) check(ioRdValid === expValid, "read valid");
      if (lastCe && expValid) check(ioRdData === expData, "read data");
      check(timerClockRunning === expRun, "clock watch");
    end
  end

  task automatic run(input int n, input bit work, input bit pinOn, input bit ceRand, input bit mrOn);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      inputClockPin = pinOn & 1'($urandom_range(0, 1));
      systemWorking = work;
      clkEnable = ceRand ? 1'($urandom_range(0, 3) != 0) : 1'b1;
      masterReset = mrOn & ($urandom_range(0, 31) == 0);
      timerCarryClear = 1'($urandom_range(0, 1));
      {timerCarryIrqEnable, sciSelect, smiEnable} = 3'($urandom_range(0, 7));
    end
  endtask : run

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Watchdog sized well past the roughly 6000 cycles the tests take.
  initial begin
    #(20 * 20000);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {reset, clkEnable, inputClockPin, systemWorking, masterReset, hostOn} = 6'h30;
    {timerCarryClear, timerCarryIrqEnable, sciSelect, smiEnable} = 4'h0;
    void'($urandom(32'hDD5AE32C));
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    #1;
    check(pmTimerCount === 24'h000000 && ioRdValid === 1'b0, "reset values");
    hostOn = 1'b1;
    run(3000, 1, 1, 0, 0);
    $display("test count_and_read done");
    run(2, 0, 1, 0, 0);
    held = expCount;
    run(500, 0, 1, 0, 0);
    check(pmTimerCount === 24'(held), "counted outside working state");
    $display("test not_working done");
    run(100, 1, 0, 0, 0);
    check(timerClockRunning === 1'b0 && pmTimerCount === 24'(held), "stopped pin");
    run(200, 1, 1, 0, 0);
    check(timerClockRunning === 1'b1 && pmTimerCount > 24'(held), "no resume");
    $display("test stop_restart done");
    run(1000, 1, 1, 1, 0);
    $display("test clock_enable done");
    run(1000, 1, 1, 0, 1);
    $display("test master_reset done");
    @(posedge clk_sys);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    check(pmTimerCount === 24'h000000 && timerClockRunning === 1'b0, "mid-run reset");
    run(300, 1, 1, 0, 0);
    $display("test mid_reset done");
    test_done();
  end
endmodule : acpi_pm_timer_tb
